// [core/ltd_decoder.sv]
// instruction length and execution timing decoder for the 8-bit core
`timescale 1ns/100ps
`default_nettype none
`include "ltd_defs.svh"
module ltd_decoder (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic op_valid_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] operand1_i,
    input wire logic [7:0] operand2_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] acc_i,
    input wire logic [15:0] data_pointer_i,
    input wire logic [15:0] return_addr_i,
    input wire logic carry_i,
    input wire logic bit_value_i,
    input wire logic cache_miss_i,
    output logic ready_o,
    output logic done_o,
    output logic known_o,
    output logic [1:0] inst_len_o,
    output logic [3:0] base_cycles_o,
    output logic [3:0] total_cycles_o,
    output logic [15:0] next_pc_o,
    output logic branch_o,
    output logic taken_o,
    output logic [15:0] target_o,
    output logic bit_clear_o
);

    // length and base time packed together to keep the table short
    function automatic logic [5:0] lc(input logic [1:0] l, input logic [3:0] c);
        return {l, c};
    endfunction

    logic [5:0] lc_v;
    ltd_pkg::ltd_br_t kind_v;
    ltd_pkg::ltd_cond_t cond_v;
    logic is_cond_v;
    logic clr_bit_v;
    logic known_v;

    // opcode table; no opcode matches two entries, so their order does not matter
    always_comb begin
        lc_v = lc(`LTD_LEN1, `LTD_CYC1);
        kind_v = ltd_pkg::LTD_BR_NONE;
        cond_v = ltd_pkg::LTD_CC_ALWAYS;
        is_cond_v = 1'b0;
        clr_bit_v = 1'b0;
        known_v = 1'b1;
        casez (opcode_i)
            8'h14, 8'ha3, 8'hd4, 8'he4, 8'hf4: lc_v = lc(`LTD_LEN1, `LTD_CYC1);
            8'h23, 8'h33, 8'h03, 8'h13, 8'hc4: lc_v = lc(`LTD_LEN1, `LTD_CYC1);
            8'ha4: lc_v = lc(`LTD_LEN1, `LTD_CYC4);
            8'h84: lc_v = lc(`LTD_LEN1, `LTD_CYC8);
            8'h54, 8'h44, 8'h64, 8'h74: lc_v = lc(`LTD_LEN2, `LTD_CYC2);
            8'h52, 8'h42, 8'h62, 8'hf5: lc_v = lc(`LTD_LEN2, `LTD_CYC2);
            8'h53, 8'h43, 8'h63: lc_v = lc(`LTD_LEN3, `LTD_CYC3);
            8'h85, 8'h75: lc_v = lc(`LTD_LEN3, `LTD_CYC3);
            8'h90: lc_v = lc(`LTD_LEN3, `LTD_CYC3);
            8'h93, 8'h83: lc_v = lc(`LTD_LEN1, `LTD_CYC3);
            8'he0, 8'hf0, 8'b1110_001?, 8'b1111_001?: lc_v = lc(`LTD_LEN1, `LTD_CYC3);
            8'hc0, 8'hd0: lc_v = lc(`LTD_LEN2, `LTD_CYC2);
            8'b1101_011?: lc_v = lc(`LTD_LEN1, `LTD_CYC2);
            8'hc3, 8'hd3, 8'hb3: lc_v = lc(`LTD_LEN1, `LTD_CYC1);
            8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0: lc_v = lc(`LTD_LEN2, `LTD_CYC2);
            8'h72, 8'ha0, 8'ha2, 8'h92: lc_v = lc(`LTD_LEN2, `LTD_CYC2);
            8'b1111_1???: lc_v = lc(`LTD_LEN1, `LTD_CYC1);
            8'b1010_1???, 8'b0111_1???: lc_v = lc(`LTD_LEN2, `LTD_CYC2);
            8'b1000_1???, 8'b1000_011?: lc_v = lc(`LTD_LEN2, `LTD_CYC2);
            8'b1111_011?: lc_v = lc(`LTD_LEN1, `LTD_CYC2);
            8'b1010_011?, 8'b0111_011?: lc_v = lc(`LTD_LEN2, `LTD_CYC2);
            // accumulator rows: decrement, or, and, xor, exchange, load acc
            8'b0001_1???, 8'b0100_1???, 8'b0101_1???, 8'b0110_1???, 8'b1100_1???, 8'b1110_1???: begin
                lc_v = lc(`LTD_LEN1, `LTD_CYC1);
            end
            8'h15, 8'h45, 8'h55, 8'h65, 8'hc5, 8'he5: lc_v = lc(`LTD_LEN2, `LTD_CYC2);
            8'b0001_011?, 8'b0100_011?, 8'b0101_011?, 8'b0110_011?, 8'b1100_011?, 8'b1110_011?: begin
                lc_v = lc(`LTD_LEN1, `LTD_CYC2);
            end
            8'h40, 8'h50: begin
                lc_v = lc(`LTD_LEN2, `LTD_CYC2);
                kind_v = ltd_pkg::LTD_BR_REL;
                // the no-carry form differs only in bit 4; if/else keeps the enum assignment strictly typed
                if (opcode_i[4]) begin
                    cond_v = ltd_pkg::LTD_CC_NCARRY;
                end else begin
                    cond_v = ltd_pkg::LTD_CC_CARRY;
                end
                is_cond_v = 1'b1;
            end
            8'h10, 8'h20, 8'h30: begin
                lc_v = lc(`LTD_LEN3, `LTD_CYC3);
                kind_v = ltd_pkg::LTD_BR_REL;
                if (opcode_i == 8'h30) begin
                    cond_v = ltd_pkg::LTD_CC_NBIT;
                end else begin
                    cond_v = ltd_pkg::LTD_CC_BIT;
                end
                is_cond_v = 1'b1;
                clr_bit_v = (opcode_i == 8'h10);
            end
            8'h80: begin
                lc_v = lc(`LTD_LEN2, `LTD_CYC3);
                kind_v = ltd_pkg::LTD_BR_REL;
            end
            8'b???0_0001, 8'b???1_0001: begin
                lc_v = lc(`LTD_LEN2, `LTD_CYC3);
                kind_v = ltd_pkg::LTD_BR_PAGE;
            end
            8'h02, 8'h12: begin
                lc_v = lc(`LTD_LEN3, `LTD_CYC4);
                kind_v = ltd_pkg::LTD_BR_LONG;
            end
            8'h73: begin
                lc_v = lc(`LTD_LEN1, `LTD_CYC3);
                kind_v = ltd_pkg::LTD_BR_INDIR;
            end
            8'h22, 8'h32: begin
                lc_v = lc(`LTD_LEN1, `LTD_CYC5);
                kind_v = ltd_pkg::LTD_BR_RET;
            end
            default: known_v = 1'b0; // rows this block does not time
        endcase
    end

    logic [15:0] npc_v;
    logic [7:0] rel_v;
    logic cond_ok_v;
    logic take_v;
    logic [15:0] tgt_v;
    logic [3:0] tot_v;

    // branch outcome, target and total time of the presented opcode
    always_comb begin
        npc_v = pc_i + {14'h0000, lc_v[5:4]};
        rel_v = (lc_v[5:4] == `LTD_LEN3) ? operand2_i : operand1_i;
        case (cond_v)
            ltd_pkg::LTD_CC_CARRY: cond_ok_v = carry_i;
            ltd_pkg::LTD_CC_NCARRY: cond_ok_v = ~carry_i;
            ltd_pkg::LTD_CC_BIT: cond_ok_v = bit_value_i;
            ltd_pkg::LTD_CC_NBIT: cond_ok_v = ~bit_value_i;
            default: cond_ok_v = 1'b1;
        endcase
        take_v = (kind_v != ltd_pkg::LTD_BR_NONE) && cond_ok_v;
        case (kind_v)
            ltd_pkg::LTD_BR_REL: tgt_v = npc_v + {{8{rel_v[7]}}, rel_v};
            ltd_pkg::LTD_BR_PAGE: begin
                tgt_v = {npc_v[`LTD_PAGE_HI_MSB:`LTD_PAGE_HI_LSB], opcode_i[7:5], operand1_i};
            end
            ltd_pkg::LTD_BR_LONG: tgt_v = {operand1_i, operand2_i};
            ltd_pkg::LTD_BR_INDIR: tgt_v = data_pointer_i + {8'h00, acc_i};
            ltd_pkg::LTD_BR_RET: tgt_v = return_addr_i;
            default: tgt_v = npc_v;
        endcase
        tot_v = lc_v[3:0];
        // fall-through is the base figure; taking the branch adds one
        if (is_cond_v && take_v) begin
            tot_v = tot_v + `LTD_TAKEN_EXTRA;
        end
        // only a taken branch fetches its target, so only it can miss
        if (take_v && cache_miss_i) begin
            tot_v = tot_v + `LTD_MISS_PENALTY;
        end
    end

    // results are latched at accept so operand changes while busy cannot disturb them
    ltd_pkg::ltd_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic ready_q, ready_d;
    logic done_q, done_d;
    logic known_q, known_d;
    logic [1:0] len_q, len_d;
    logic [3:0] base_q, base_d;
    logic [3:0] tot_q, tot_d;
    logic [15:0] npc_q, npc_d;
    logic branch_q, branch_d;
    logic taken_q, taken_d;
    logic [15:0] tgt_q, tgt_d;
    logic clr_q, clr_d;

    // accept one opcode while idle, then stall for its full time
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        ready_d = ready_q;
        done_d = 1'b0;
        known_d = known_q;
        len_d = len_q;
        base_d = base_q;
        tot_d = tot_q;
        npc_d = npc_q;
        branch_d = branch_q;
        taken_d = taken_q;
        tgt_d = tgt_q;
        clr_d = clr_q;
        case (state_q)
            ltd_pkg::LTD_IDLE: begin
                if (op_valid_i) begin
                    known_d = known_v;
                    len_d = lc_v[5:4];
                    base_d = lc_v[3:0];
                    tot_d = tot_v;
                    npc_d = take_v ? tgt_v : npc_v;
                    branch_d = (kind_v != ltd_pkg::LTD_BR_NONE);
                    taken_d = take_v;
                    tgt_d = tgt_v;
                    clr_d = clr_bit_v && bit_value_i;
                    cnt_d = tot_v;
                    ready_d = 1'b0;
                    state_d = ltd_pkg::LTD_EXEC;
                end
            end
            ltd_pkg::LTD_EXEC: begin
                cnt_d = cnt_q - 4'h1;
                // last clock of the instruction: release fetch
                if (cnt_q == `LTD_CYC1) begin
                    done_d = 1'b1;
                    ready_d = 1'b1;
                    state_d = ltd_pkg::LTD_IDLE;
                end
            end
            // an illegal state falls back to idle and frees fetch rather than hanging the core
            default: begin
                ready_d = 1'b1;
                state_d = ltd_pkg::LTD_IDLE;
            end
        endcase
    end

    // state and result registers
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ltd_pkg::LTD_IDLE;
            cnt_q <= 4'h0;
            ready_q <= 1'b1;
            done_q <= 1'b0;
            known_q <= 1'b0;
            len_q <= 2'h0;
            base_q <= 4'h0;
            tot_q <= 4'h0;
            npc_q <= 16'h0000;
            branch_q <= 1'b0;
            taken_q <= 1'b0;
            tgt_q <= 16'h0000;
            clr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
            done_q <= done_d;
            known_q <= known_d;
            len_q <= len_d;
            base_q <= base_d;
            tot_q <= tot_d;
            npc_q <= npc_d;
            branch_q <= branch_d;
            taken_q <= taken_d;
            tgt_q <= tgt_d;
            clr_q <= clr_d;
        end
    end

    // outputs come straight from flip-flops so pipeline control sees no decode glitches
    assign ready_o = ready_q;
    assign done_o = done_q;
    assign known_o = known_q;
    assign inst_len_o = len_q;
    assign base_cycles_o = base_q;
    assign total_cycles_o = tot_q;
    assign next_pc_o = npc_q;
    assign branch_o = branch_q;
    assign taken_o = taken_q;
    assign target_o = tgt_q;
    assign bit_clear_o = clr_q;

endmodule
`default_nettype wire

// [core/ltd_defs.svh]
// constants for the instruction length and timing decoder
`ifndef LTD_DEFS_SVH
`define LTD_DEFS_SVH
// instruction lengths in bytes
`define LTD_LEN1 2'h1
`define LTD_LEN2 2'h2
`define LTD_LEN3 2'h3
// base execution times in system clocks
`define LTD_CYC1 4'h1
`define LTD_CYC2 4'h2
`define LTD_CYC3 4'h3
`define LTD_CYC4 4'h4
`define LTD_CYC5 4'h5
`define LTD_CYC8 4'h8
// a taken conditional branch costs one clock more than a fall-through
`define LTD_TAKEN_EXTRA 4'h1
// extra clocks when a taken branch target misses the branch target cache
`define LTD_MISS_PENALTY 4'h2
// page jump/call: upper address bits kept from the following instruction
`define LTD_PAGE_HI_MSB 15
`define LTD_PAGE_HI_LSB 11
`endif

// [core/ltd_pkg.sv]
// types shared by the instruction length and timing decoder
`default_nettype none
package ltd_pkg;
    // decoder control state, gray along idle -> exec -> idle
    typedef enum logic [1:0] {
        LTD_IDLE = 2'b00,
        LTD_EXEC = 2'b01
    } ltd_state_t;
    // how the branch target is formed
    typedef enum logic [2:0] {
        LTD_BR_NONE = 3'h0,
        LTD_BR_REL = 3'h1,
        LTD_BR_PAGE = 3'h2,
        LTD_BR_LONG = 3'h3,
        LTD_BR_INDIR = 3'h4,
        LTD_BR_RET = 3'h5
    } ltd_br_t;
    // branch condition
    typedef enum logic [2:0] {
        LTD_CC_ALWAYS = 3'h0,
        LTD_CC_CARRY = 3'h1,
        LTD_CC_NCARRY = 3'h2,
        LTD_CC_BIT = 3'h3,
        LTD_CC_NBIT = 3'h4
    } ltd_cond_t;
endpackage
`default_nettype wire

// [tb/ltd_decoder_chk.sv]
// assertion checker for the length and timing decoder
`timescale 1ns/100ps
`default_nettype none
module ltd_decoder_chk (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic op_valid_i,
    input wire logic [7:0] opcode_i,
    input wire logic [15:0] pc_i,
    input wire logic cache_miss_i,
    input wire logic ready_o,
    input wire logic done_o,
    input wire logic [1:0] inst_len_o,
    input wire logic [3:0] base_cycles_o,
    input wire logic [3:0] total_cycles_o,
    input wire logic [15:0] next_pc_o,
    input wire logic taken_o,
    input wire logic [15:0] target_o,
    input wire logic bit_clear_o
);
    logic acc_w;
    logic [15:0] pc_q;
    logic [7:0] op_q;
    logic miss_q;
    assign acc_w = ready_o && op_valid_i;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // inputs move on after accept, so keep what the instruction in flight was taken with
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pc_q <= 16'h0000;
            op_q <= 8'h00;
            miss_q <= 1'b0;
        end else if (acc_w) begin
            pc_q <= pc_i;
            op_q <= opcode_i;
            miss_q <= cache_miss_i;
        end
    end
    a_accept_busy: assert property (acc_w |=> !ready_o && !done_o) else $error("accept did not start");
    a_done_ready: assert property (done_o |-> ready_o) else $error("done without ready");
    a_not_taken: assert property (done_o && !taken_o |-> total_cycles_o == base_cycles_o
        && next_pc_o == pc_q + {14'h0000, inst_len_o}) else $error("fall-through wrong");
    a_taken_cost: assert property (done_o && taken_o |->
        (total_cycles_o - base_cycles_o - (miss_q ? 4'h2 : 4'h0)) <= 4'h1) else $error("taken cost wrong");
    a_page_hi: assert property (done_o && taken_o && op_q[3:0] == 4'h1 |->
        (next_pc_o >> 11) == ((pc_q + 16'h0002) >> 11)) else $error("page target left page");
    a_mul_four: assert property (done_o && op_q == 8'ha4 |-> total_cycles_o == 4'h4 && inst_len_o == 2'h1)
        else $error("multiply timing wrong");
    a_div_eight: assert property (acc_w && opcode_i == 8'h84 |=> !ready_o [*8] ##1 ready_o && done_o)
        else $error("divide timing wrong");
    a_clear_taken: assert property (done_o && bit_clear_o |-> taken_o && op_q == 8'h10)
        else $error("bit clear without taken test-clear");
    a_results_hold: assert property (!ready_o |=> $stable(target_o) && $stable(inst_len_o))
        else $error("results moved while busy");
    c_taken_miss: cover property (done_o && taken_o && miss_q);
    c_divide: cover property (acc_w && opcode_i == 8'h84);
    c_bit_clear: cover property (done_o && bit_clear_o);
endmodule
bind ltd_decoder ltd_decoder_chk chk_u (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .op_valid_i(op_valid_i), .opcode_i(opcode_i),
    .pc_i(pc_i), .cache_miss_i(cache_miss_i), .ready_o(ready_o), .done_o(done_o), .inst_len_o(inst_len_o),
    .base_cycles_o(base_cycles_o), .total_cycles_o(total_cycles_o), .next_pc_o(next_pc_o),
    .taken_o(taken_o), .target_o(target_o), .bit_clear_o(bit_clear_o)
);
`default_nettype wire

// [tb/ltd_fetch_model.sv]
// fetch unit and pipeline control model: follows next pc and counts stall clocks
`timescale 1ns/100ps
`default_nettype none
module ltd_fetch_model (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ready_i,
    input wire logic done_i,
    input wire logic [15:0] next_pc_i,
    output logic [15:0] pc_o,
    output logic [3:0] busy_cnt_o
);
    // a wrong successor shows up as a wandering fetch address, never silently corrected
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pc_o <= 16'h07f0;
            busy_cnt_o <= 4'h0;
        end else begin
            if (done_i) pc_o <= next_pc_i; // fetch advances to the decoded successor
            // counts from the accept edge, so it reads the full time in the done cycle
            busy_cnt_o <= ready_i ? 4'h0 : busy_cnt_o + 4'h1; // stall clocks of the instruction
        end
    end
endmodule
`default_nettype wire

// [tb/tb_cpu_instruction_length_timing_decoder.sv]
// self-checking bench for the length and timing decoder
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_instruction_length_timing_decoder;
    logic clk = 1'b0, rstn = 1'b0, vld = 1'b0, cy = 1'b0, bv = 1'b0, miss = 1'b0;
    logic [7:0] op = 8'h00, o1 = 8'h00, o2 = 8'h00, acc = 8'h00;
    logic [15:0] dp = 16'h0000, ra = 16'h0000, pc_w;
    logic ready_o, done_o, known_o, branch_o, taken_o, bit_clear_o;
    logic [1:0] inst_len_o;
    logic [3:0] base_cycles_o, total_cycles_o, busy_cnt;
    logic [15:0] next_pc_o, target_o;
    logic [45:0] expq[$];
    logic [45:0] r;
    int fails = 0, checked = 0, seed = 79;
    // op, len, clocks, kind: 1 carry 2 no carry 3 bit 4 rel 5 page 6 long 7 indirect 8 return 9 no bit f unknown
    logic [19:0] tbl[0:31] = '{20'h18110, 20'h16120, 20'h15220, 20'h53330,
        20'h84180, 20'ha4140, 20'hd4110, 20'ha3110, 20'h74220, 20'h85330,
        20'hf6120, 20'h76220, 20'h90330, 20'h93130, 20'he0130, 20'hc0220,
        20'hd6120, 20'hc3110, 20'h82220, 20'h40221, 20'h50222, 20'h20333,
        20'h10333, 20'h30339, 20'h80234, 20'h01235, 20'h11235, 20'h73137, 20'h02346,
        20'h22158, 20'h32158, 20'h2411f};
    ltd_decoder dut_u (.core_clk_i(clk), .resetn_i(rstn), .op_valid_i(vld), .opcode_i(op), .operand1_i(o1),
        .operand2_i(o2), .pc_i(pc_w), .acc_i(acc), .data_pointer_i(dp), .return_addr_i(ra), .carry_i(cy),
        .bit_value_i(bv), .cache_miss_i(miss), .ready_o(ready_o), .done_o(done_o), .known_o(known_o),
        .inst_len_o(inst_len_o), .base_cycles_o(base_cycles_o), .total_cycles_o(total_cycles_o),
        .next_pc_o(next_pc_o), .branch_o(branch_o), .taken_o(taken_o), .target_o(target_o),
        .bit_clear_o(bit_clear_o));
    ltd_fetch_model fetch_u (.core_clk_i(clk), .resetn_i(rstn), .ready_i(ready_o), .done_i(done_o),
        .next_pc_i(next_pc_o), .pc_o(pc_w), .busy_cnt_o(busy_cnt));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (e !== g) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // present one instruction when the decoder is idle and note what it must report
    task automatic run(input int i);
        logic [7:0] o, off;
        logic [3:0] k, b, t;
        logic [1:0] l;
        logic tk;
        logic [15:0] nx, tg;
        {o, l, b, k} = {tbl[i][19:12], tbl[i][9:8], tbl[i][7:4], tbl[i][3:0]};
        @(negedge clk);
        while (!ready_o) @(negedge clk);
        {op, o1, o2, acc, cy, bv, miss} = {o, 8'($random(seed)), 8'($random(seed)), 8'($random(seed)), 3'($random(seed))};
        dp = 16'($random(seed));
        ra = 16'($random(seed));
        vld = 1'b1;
        tk = (k == 4'h1) ? cy : (k == 4'h2) ? !cy : (k == 4'h3) ? bv : (k == 4'h9) ? !bv :
            (k >= 4'h4 && k <= 4'h8);
        off = (l == 2'h3) ? o2 : o1;
        nx = pc_w + {14'h0000, l};
        // a branch forms its target taken or not; plain opcodes report the successor as target
        case (k)
            4'h0, 4'hf: tg = nx;
            4'h5: tg = {nx[15:11], o[7:5], o1};
            4'h6: tg = {o1, o2};
            4'h7: tg = {8'h00, acc} + dp;
            4'h8: tg = ra;
            default: tg = nx + {{8{off[7]}}, off};
        endcase
        if (tk) nx = tg;
        t = b + (((k < 4'h4 || k == 4'h9) && tk) ? 4'h1 : 4'h0) + ((tk && miss) ? 4'h2 : 4'h0);
        expq.push_back({k != 4'hf, (k == 4'hf) ? 2'h1 : l, (k == 4'hf) ? 4'h1 : b, (k == 4'hf) ? 4'h1 : t, nx, tk,
            o == 8'h10 && bv, tg, k != 4'h0 && k != 4'hf});
        @(negedge clk);
        // a second request while busy must be ignored
        if (t >= 4'h3) begin
            op = op ^ 8'h5a;
            @(negedge clk);
        end
        vld = 1'b0;
    endtask
    // take the oldest note whenever an instruction completes
    always @(negedge clk) begin
        if (rstn && done_o) begin
            cmp("queue", 16'h0000, {15'h0000, expq.size() == 0});
            r = expq.pop_front();
            cmp("known", {15'h0000, r[45]}, {15'h0000, known_o});
            cmp("len", {14'h0000, r[44:43]}, {14'h0000, inst_len_o});
            cmp("base", {12'h000, r[42:39]}, {12'h000, base_cycles_o});
            cmp("total", {12'h000, r[38:35]}, {12'h000, total_cycles_o});
            cmp("stall", {12'h000, r[38:35]}, {12'h000, busy_cnt});
            cmp("next_pc", r[34:19], next_pc_o);
            cmp("taken", {15'h0000, r[18]}, {15'h0000, taken_o});
            cmp("bit_clear", {15'h0000, r[17]}, {15'h0000, bit_clear_o});
            cmp("target", r[16:1], target_o);
            cmp("branch", {15'h0000, r[0]}, {15'h0000, branch_o});
        end
    end
    initial begin
        #(50 * 6000);
        fails++;
        end_sim();
    end
    initial begin
        repeat (5) @(negedge clk);
        cmp("ready", 16'h0001, {15'h0000, ready_o});
        rstn = 1'b1;
        repeat (6) begin
            for (int i = 0; i < 32; i++) run(i);
        end
        repeat (12) @(negedge clk);
        cmp("left", 16'h0000, 16'(expq.size()));
        end_sim();
    end
endmodule
`default_nettype wire
